// ---- src/eicr_regs.sv ----
/*
 * register bank and control of the external interrupt controller, with the
 * enable/soft-reset handshake toward the generic detection side and nmi detection.
 * assumes pin detection logic outside delivers one-cycle hit pulses on sys_clk and
 * that the generic detection clock arrives as a plain pin input.
 */
// The address-and-strobe port was chosen for this implementation.
// Operation
// R1: registers are 8, 16 or 32 bits; single 8/16/32-bit accesses work.
// R2: each byte or halfword of a register is reachable directly.
// R3: enable-protected registers take writes only while the controller is disabled.
// R4: write-protected registers ignore writes while access protection is asserted.
// R5: enable bit reads back at once; controller switches after synchronisation.
// R6: writing enable sets busy at once; busy clears when the switch completes.
// R7: soft reset returns all registers to reset values and disables the controller.
// R8: a write setting soft reset discards all other fields of that write.
// R9: writing zero to soft reset has no effect.
// R10: soft reset reads one until done; it and busy clear together.
// R11: status bit 7 is busy; set at sync start, cleared at sync end.
// R12: reserved bits of control and status read zero.
// R13: software writes zero to reserved bits.
// R14: sense codes 0 none,1 rise,2 fall,3 both,4 high,5 low; 6,7 reserved.
// R15: with filter on, three generic-clock samples are majority voted.
// R16: a sync access while busy is held and completes after the sync.
// R17: flags clear on writing one; writing zero leaves them.
// R18: enable and reset cross by request/acknowledge; busy holds until ack returns.
`timescale 1ns/1ps
`default_nettype none
module eicr_regs
   import eicr_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            rst_b,
   input  wire eicr_bus_t       busIn,
   output logic [31:0]          rdData,
   input  wire logic            protectOn,
   input  wire logic [17:0]     pinIrqHit,
   input  wire logic            nmiPin,
   input  wire logic            genClk,
   output eicr_cfg_t            cfgOut,
   output logic                 detEnable,
   output logic                 irqReq,
   output logic                 nmiReq,
   output logic [17:0]          irqFlags,
   output logic                 sync_in_progress,
   output logic                 ctrlStall
);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lane_merge(input logic [31:0] oldV, input logic [31:0] newV,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = oldV;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = newV[8*i +: 8];
         end
      end
      return res;
   endfunction

   // reserved sense codes are stored as no detection so pin logic never sees them
   function automatic logic [31:0] sense_legal(input logic [31:0] v);
      logic [31:0] res;
      res = v;
      for (int i = 0; i < 8; i++) begin
         if (v[4*i +: 3] > SENSE_LOW) begin
            res[4*i +: 3] = SENSE_NONE;
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   eicr_cfg_t   cfg_q;
   eicr_sync_t  state_q;
   logic [17:0] intEn_q;
   logic [17:0] flags_q;
   logic        nonmaskable_flag_q;
   logic        ctrlEnable_q;
   logic        soft_reset_trigger_q;
   logic        busy_q;
   logic        req_q;
   logic        genAck_q;
   logic        ackS1_q;
   logic        ackS2_q;
   logic        genEnable_q;
   logic        pendValid_q;
   logic [7:0]  pendData_q;
   logic [31:0] rdData_q;
   logic        irqReq_q;
   logic        nmiReq_q;
   logic [3:0]  wordSel;
   logic        wrWord0;
   logic        enabled;
   logic        ctrlHit;
   logic        takeNew;
   logic        ctrlWrNow;
   logic [7:0]  ctrlData;
   logic        doSwrst;
   logic        genEdge;
   logic [31:0] rdWord;

   assign wordSel = busIn.addr[5:2];
   assign wrWord0 = busIn.wr && (wordSel == OFF_CTRL[5:2]);
   assign enabled = ctrlEnable_q | genEnable_q;

   ////////////////////////////////////////////////////////////////////////////////
   // control writes: a write arriving while busy is parked, not lost
   assign ctrlHit   = wrWord0 && busIn.byteEn[0] && !protectOn;                        // [R4]
   assign takeNew   = ctrlHit && (state_q == SY_IDLE) && !pendValid_q;
   assign ctrlWrNow = takeNew || (pendValid_q && (state_q == SY_IDLE));                // [R16]
   assign ctrlData  = takeNew ? busIn.wdata[7:0] : pendData_q;
   assign doSwrst   = ctrlWrNow && ctrlData[CTRL_SOFT_RESET_TRIGGER];                               // [R9]

   always_ff @(posedge sys_clk) begin
      if (!rst_b || doSwrst) begin
         pendValid_q <= 1'b0;
         pendData_q  <= CTRL_RST;
      end else if (ctrlHit && !takeNew) begin
         pendValid_q <= 1'b1;                                                          // [R16]
         pendData_q  <= busIn.wdata[7:0];
      end else if (ctrlWrNow) begin
         pendValid_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrlEnable_q <= 1'b0;
         soft_reset_trigger_q      <= 1'b0;
      end else if (doSwrst) begin
         ctrlEnable_q <= 1'b0;                                                         // [R7] [R8]
         soft_reset_trigger_q      <= 1'b1;                                                         // [R10]
      end else if (ctrlWrNow) begin
         ctrlEnable_q <= ctrlData[CTRL_ENABLE];                                        // [R5]
      end else if (state_q == SY_DROP && !ackS2_q) begin
         soft_reset_trigger_q      <= 1'b0;                                                         // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // four-phase handshake; the acknowledge returns through two flops
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= SY_IDLE;
         req_q   <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         case (state_q)
            SY_IDLE: begin
               if (ctrlWrNow) begin
                  state_q <= SY_REQ;
                  req_q   <= 1'b1;                                                     // [R18]
                  busy_q  <= 1'b1;                                                     // [R6] [R11]
               end
            end
            SY_REQ: begin
               if (ackS2_q) begin
                  state_q <= SY_DROP;
                  req_q   <= 1'b0;
               end
            end
            SY_DROP: begin
               if (!ackS2_q) begin
                  state_q <= SY_IDLE;
                  busy_q  <= 1'b0;                                                     // [R6] [R10] [R18]
               end
            end
            default: begin
               state_q <= SY_IDLE;
               req_q   <= 1'b0;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ackS1_q <= 1'b0;
         ackS2_q <= 1'b0;
      end else begin
         ackS1_q <= genAck_q;
         ackS2_q <= ackS1_q;                                                           // [R18]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // generic clock pin: three flops, a rising edge counts once stages two and three agree
   logic genS1_q, genS2_q, genS3_q, genLvl_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         genS1_q  <= 1'b0;
         genS2_q  <= 1'b0;
         genS3_q  <= 1'b0;
         genLvl_q <= 1'b0;
      end else begin
         genS1_q  <= genClk;
         genS2_q  <= genS1_q;
         genS3_q  <= genS2_q;
         genLvl_q <= (genS2_q == genS3_q) ? genS3_q : genLvl_q;
      end
   end
   assign genEdge = !genLvl_q && genS2_q && genS3_q;

   // generic side acts only on its own edges, so it stands still without that clock
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         genAck_q    <= 1'b0;
         genEnable_q <= 1'b0;
      end else if (genEdge) begin
         genAck_q <= req_q;                                                            // [R18]
         if (req_q && !genAck_q) begin
            genEnable_q <= soft_reset_trigger_q ? 1'b0 : ctrlEnable_q;                              // [R5] [R7]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [31:0] evNew;
   logic [31:0] wakeNew;
   assign evNew   = lane_merge({14'h0000, cfg_q.evOutEn}, busIn.wdata, busIn.byteEn);
   assign wakeNew = lane_merge({14'h0000, cfg_q.wakeEn}, busIn.wdata, busIn.byteEn);
   always_ff @(posedge sys_clk) begin
      if (!rst_b || doSwrst) begin
         cfg_q <= '0;                                                                  // [R7]
      end else if (busIn.wr && !protectOn) begin                                       // [R4]
         if (wrWord0 && busIn.byteEn[2]) begin
            cfg_q.nmiFilt  <= busIn.wdata[16 + NMI_FILT];
            cfg_q.nonmaskable_sense_sel <= (busIn.wdata[18:16] > SENSE_LOW) ? SENSE_NONE : busIn.wdata[18:16]; // [R14]
         end
         if (!enabled) begin                                                           // [R3]
            if (wordSel == OFF_EVOUT[5:2]) begin
               cfg_q.evOutEn <= evNew[NUM_PINS-1:0];                                    // [R1] [R2]
            end else if (wordSel == OFF_WAKE[5:2]) begin
               cfg_q.wakeEn <= wakeNew[NUM_PINS-1:0];
            end else if (wordSel == OFF_CFGA[5:2]) begin
               cfg_q.cfgA <= sense_legal(lane_merge(cfg_q.cfgA, busIn.wdata, busIn.byteEn)); // [R14]
            end else if (wordSel == OFF_CFGB[5:2]) begin
               cfg_q.cfgB <= sense_legal(lane_merge(cfg_q.cfgB, busIn.wdata, busIn.byteEn));
            end else if (wordSel == OFF_CFGC[5:2]) begin
               cfg_q.cfgC <= sense_legal(lane_merge(cfg_q.cfgC, busIn.wdata, busIn.byteEn));
            end
         end
      end
   end

   // interrupt enables: set and clear views of one register
   logic [31:0] ienWr;
   assign ienWr = lane_merge(WORD_RST, busIn.wdata, busIn.byteEn);                     // [R2]
   always_ff @(posedge sys_clk) begin
      if (!rst_b || doSwrst) begin
         intEn_q <= PINS_RST;
      end else if (busIn.wr && !protectOn) begin
         if (wordSel == OFF_IENCLR[5:2]) begin
            intEn_q <= intEn_q & ~ienWr[NUM_PINS-1:0];
         end else if (wordSel == OFF_IENSET[5:2]) begin
            intEn_q <= intEn_q | ienWr[NUM_PINS-1:0];
         end
      end
   end

   // flags: a hit in the same cycle as its clear wins
   logic [17:0] flagClr;
   assign flagClr = (busIn.wr && wordSel == OFF_IFLAG[5:2]) ? ienWr[NUM_PINS-1:0] : PINS_RST;
   always_ff @(posedge sys_clk) begin
      if (!rst_b || doSwrst) begin
         flags_q <= PINS_RST;
      end else begin
         flags_q <= (flags_q & ~flagClr) | pinIrqHit;                                  // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // nmi pin: three-flop input, optional majority filter, sense detection
   logic nmiS1_q, nmiS2_q, nmiS3_q, nmiLvl_q, nmiPrev_q, nmiVal, nmiHit, nmiClr;
   logic [2:0] nmiSmp_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         nmiS1_q  <= 1'b0;
         nmiS2_q  <= 1'b0;
         nmiS3_q  <= 1'b0;
         nmiLvl_q <= 1'b0;
         nmiSmp_q <= 3'h0;
      end else begin
         nmiS1_q  <= nmiPin;
         nmiS2_q  <= nmiS1_q;
         nmiS3_q  <= nmiS2_q;
         nmiLvl_q <= (nmiS2_q == nmiS3_q) ? nmiS3_q : nmiLvl_q;
         if (genEdge) begin
            nmiSmp_q <= {nmiSmp_q[1:0], nmiLvl_q};                                     // [R15]
         end
      end
   end
   assign nmiVal = cfg_q.nmiFilt ?
                   ((nmiSmp_q[0] & nmiSmp_q[1]) | (nmiSmp_q[0] & nmiSmp_q[2]) | (nmiSmp_q[1] & nmiSmp_q[2])) // [R15]
                   : nmiLvl_q;

   always_comb begin
      case (cfg_q.nonmaskable_sense_sel)                                                            // [R14]
         SENSE_RISE: nmiHit = nmiVal && !nmiPrev_q;
         SENSE_FALL: nmiHit = !nmiVal && nmiPrev_q;
         SENSE_BOTH: nmiHit = nmiVal != nmiPrev_q;
         SENSE_HIGH: nmiHit = nmiVal;
         SENSE_LOW:  nmiHit = !nmiVal;
         default:    nmiHit = 1'b0;
      endcase
   end

   assign nmiClr = wrWord0 && busIn.byteEn[3] && busIn.wdata[24 + NONMASKABLE_FLAG_BIT];
   always_ff @(posedge sys_clk) begin
      if (!rst_b || doSwrst) begin
         nmiPrev_q <= 1'b0;
         nonmaskable_flag_q <= 1'b0;
      end else begin
         nmiPrev_q <= nmiVal;
         nonmaskable_flag_q <= (nonmaskable_flag_q && !nmiClr) || nmiHit;                                // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: unmapped words read zero, data valid only in the cycle after the strobe
   always_comb begin
      rdWord = WORD_RST;
      if (wordSel == OFF_CTRL[5:2]) begin
         rdWord[CTRL_ENABLE]     = ctrlEnable_q;                                       // [R5] [R12]
         rdWord[CTRL_SOFT_RESET_TRIGGER]      = soft_reset_trigger_q;                                            // [R10]
         rdWord[8 + STATUS_BUSY] = busy_q;                                             // [R11]
         rdWord[19:16]           = {cfg_q.nmiFilt, cfg_q.nonmaskable_sense_sel};
         rdWord[24 + NONMASKABLE_FLAG_BIT] = nonmaskable_flag_q;
      end else if (wordSel == OFF_EVOUT[5:2]) begin
         rdWord[NUM_PINS-1:0] = cfg_q.evOutEn;
      end else if (wordSel == OFF_IENCLR[5:2] || wordSel == OFF_IENSET[5:2]) begin
         rdWord[NUM_PINS-1:0] = intEn_q;
      end else if (wordSel == OFF_IFLAG[5:2]) begin
         rdWord[NUM_PINS-1:0] = flags_q;
      end else if (wordSel == OFF_WAKE[5:2]) begin
         rdWord[NUM_PINS-1:0] = cfg_q.wakeEn;
      end else if (wordSel == OFF_CFGA[5:2]) begin
         rdWord = cfg_q.cfgA;
      end else if (wordSel == OFF_CFGB[5:2]) begin
         rdWord = cfg_q.cfgB;
      end else if (wordSel == OFF_CFGC[5:2]) begin
         rdWord = cfg_q.cfgC;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rdData_q <= WORD_RST;
         irqReq_q <= 1'b0;
         nmiReq_q <= 1'b0;
      end else begin
         rdData_q <= busIn.rd ? rdWord : WORD_RST;                                     // [R1]
         irqReq_q <= |(flags_q & intEn_q);
         nmiReq_q <= nonmaskable_flag_q;
      end
   end

   assign rdData    = rdData_q;
   assign cfgOut    = cfg_q;
   assign detEnable = genEnable_q;
   assign irqReq    = irqReq_q;
   assign nmiReq    = nmiReq_q;
   assign irqFlags  = flags_q;
   assign sync_in_progress  = busy_q;
   assign ctrlStall = pendValid_q;

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_ctrl_start;
      ctrlWrNow && !ctrlData[CTRL_SOFT_RESET_TRIGGER];
   endsequence

   sequence s_soft_reset_trigger_start;
      doSwrst;
   endsequence

   a_busy_on_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
      s_ctrl_start |=> busy_q && state_q == SY_REQ)
      else $error("busy not set after control write");
   a_enable_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
      s_ctrl_start |=> ctrlEnable_q == $past(ctrlData[CTRL_ENABLE]))
      else $error("enable does not read back written value");
   a_soft_reset_trigger_discard: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
      s_soft_reset_trigger_start |=> !ctrlEnable_q && soft_reset_trigger_q && cfg_q == '0 && intEn_q == PINS_RST)
      else $error("soft reset write kept other fields");
   a_soft_reset_trigger_end: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
      (state_q == SY_DROP && !ackS2_q) |=> !busy_q && !soft_reset_trigger_q)
      else $error("soft reset and busy did not clear together");
   a_protect_block: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
      (wrWord0 && busIn.byteEn[0] && protectOn && !pendValid_q) |=> !pendValid_q && $stable(ctrlEnable_q))
      else $error("protected control write took effect");
   a_enable_protect: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
      (busIn.wr && wordSel == OFF_EVOUT[5:2] && enabled) |=> $stable(cfg_q.evOutEn))
      else $error("event enables changed while enabled");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
      (busIn.rd && wordSel == OFF_CTRL[5:2]) |=> rdData_q[7:2] == 6'h00 && rdData_q[14:8] == 7'h00)
      else $error("reserved control or status bits read nonzero");
   a_status_busy: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
      (busIn.rd && wordSel == OFF_CTRL[5:2]) |=> rdData_q[15] == $past(busy_q))
      else $error("status busy bit does not show busy");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
      (flagClr[0] && !pinIrqHit[0]) |=> !flags_q[0] ##1 (flags_q[0] == $past(pinIrqHit[0])))
      else $error("flag not cleared by write of one");
   a_pend_stall: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
      (ctrlHit && busy_q && !doSwrst) |=> ctrlStall && $stable(ctrlEnable_q))
      else $error("control write during busy not held");
endmodule
`default_nettype wire

// ---- src/eicr_pkg.sv ----
/*
 * package of the external interrupt controller register bank: offsets, field positions,
 * reset values, sense codes, carrier structs and the sync state encoding.
 * assumes byte addresses on a 6-bit register port with 32-bit data and byte enables.
 */
package eicr_pkg;
   localparam int          ADDR_W        = 6;
   localparam int          NUM_PINS      = 18;
   localparam logic [5:0]  OFF_CTRL      = 6'h00;
   localparam logic [5:0]  OFF_STATUS    = 6'h01;
   localparam logic [5:0]  OFF_NMICFG    = 6'h02;
   localparam logic [5:0]  OFF_NONMASKABLE_FLAG   = 6'h03;
   localparam logic [5:0]  OFF_EVOUT     = 6'h04;
   localparam logic [5:0]  OFF_IENCLR    = 6'h08;
   localparam logic [5:0]  OFF_IENSET    = 6'h0C;
   localparam logic [5:0]  OFF_IFLAG     = 6'h10;
   localparam logic [5:0]  OFF_WAKE      = 6'h14;
   localparam logic [5:0]  OFF_CFGA      = 6'h18;
   localparam logic [5:0]  OFF_CFGB      = 6'h1C;
   localparam logic [5:0]  OFF_CFGC      = 6'h20;
   localparam int          CTRL_SOFT_RESET_TRIGGER    = 0;
   localparam int          CTRL_ENABLE   = 1;
   localparam int          STATUS_BUSY   = 7;
   localparam int          NMI_FILT      = 3;
   localparam int          NONMASKABLE_FLAG_BIT   = 0;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [3:0]  NMICFG_RST    = 4'h0;
   localparam logic [31:0] WORD_RST      = 32'h00000000;
   localparam logic [17:0] PINS_RST      = 18'h00000;
   localparam logic [2:0]  SENSE_NONE    = 3'h0;
   localparam logic [2:0]  SENSE_RISE    = 3'h1;
   localparam logic [2:0]  SENSE_FALL    = 3'h2;
   localparam logic [2:0]  SENSE_BOTH    = 3'h3;
   localparam logic [2:0]  SENSE_HIGH    = 3'h4;
   localparam logic [2:0]  SENSE_LOW     = 3'h5;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic [3:0]        byteEn;
      logic              wr;
      logic              rd;
   } eicr_bus_t;

   typedef struct packed {
      logic [17:0] evOutEn;
      logic [17:0] wakeEn;
      logic [31:0] cfgA;
      logic [31:0] cfgB;
      logic [31:0] cfgC;
      logic        nmiFilt;
      logic [2:0]  nonmaskable_sense_sel;
   } eicr_cfg_t;

   typedef enum logic [1:0] {SY_IDLE, SY_REQ, SY_DROP} eicr_sync_t;
endpackage

// ---- dv/eicr_partner.sv ----
/*
 * far-side model: the generic detection clock and the pin detection hit pulses.
 * assumes the bench calls pulse() from its own process and holds genRun high while
 * it expects any cross-domain handshake to finish.
 */
`timescale 1ns/1ps
`default_nettype none
module eicr_partner (
   input  wire logic        sys_clk,
   input  wire logic        genRun,
   output logic             genClk,
   output logic [17:0]      pinIrqHit
);
   initial begin
      genClk = 1'h0;
      pinIrqHit = 18'h00000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // 72 ns period keeps its edges off the sys_clk rising edges; stands still when genRun is low
   always begin
      #36;
      if (genRun) begin
         genClk = ~genClk;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // hits are single-cycle, as the detection side delivers them
   task automatic pulse(input logic [17:0] m);
      @(posedge sys_clk);
      pinIrqHit <= m;
      @(posedge sys_clk);
      pinIrqHit <= 18'h00000;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb_eicr_regs.sv ----
/*
 * self-checking bench of the interrupt controller register bank.
 * assumes eicr_pkg, eicr_regs and eicr_partner are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, s); end end
`define WAIT(c) #1; \
   for (int w = 0; w < 400 && !(c); w++) #10;
module tb_eicr_regs import eicr_pkg::*;;
   logic        sys_clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        protectOn = 1'h0;
   logic        nmiPin = 1'h0;
   logic        genRun = 1'h1;
   eicr_bus_t   bus = '0;
   logic [31:0] rdData;
   eicr_cfg_t   cfgOut;
   logic        detEnable, irqReq, nmiReq, sync_in_progress, ctrlStall, genClk;
   logic [17:0] irqFlags, pinIrqHit;
   logic [31:0] shadow [2] = '{32'h0, 32'h0};
   logic [3:0]  beTab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
   logic [15:0] seed = 16'h6A8D;
   int          n_errors = 0;
   int          comparisons = 0;

   always #5 sys_clk = ~sys_clk;

   eicr_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .busIn(bus), .rdData(rdData), .protectOn(protectOn),
      .pinIrqHit(pinIrqHit), .nmiPin(nmiPin), .genClk(genClk), .cfgOut(cfgOut), .detEnable(detEnable),
      .irqReq(irqReq), .nmiReq(nmiReq), .irqFlags(irqFlags), .sync_in_progress(sync_in_progress), .ctrlStall(ctrlStall));
   eicr_partner partner (.sys_clk(sys_clk), .genRun(genRun), .genClk(genClk), .pinIrqHit(pinIrqHit));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         if (be[i]) o[8*i +: 8] = d[8*i +: 8];
      end
      return o;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.byteEn <= be;
      bus.wr <= 1'h1;
      @(posedge sys_clk);
      bus.wr <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic chkRd(input logic [5:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.rd <= 1'h1;
      @(posedge sys_clk);
      bus.rd <= 1'h0;
      #1;
      `CHK("rdData", e, rdData)
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // whole sequence needs a few hundred cycles; twenty thousand means a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      finish_test();
   end
   initial begin
      logic [31:0] d;
      logic [3:0]  be;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'h1;
      for (int i = 0; i < 16; i++) chkRd(6'(4 * i), 32'h00000000);
      for (int c = 0; c < 8; c++) begin
         wr(OFF_CTRL, 32'(c) << 16, 4'h4);
         chkRd(OFF_CTRL, ((c < 6) ? (32'(c) << 16) : 32'h0) | ((c > 4) ? 32'h01000000 : 32'h0));
      end
      // low-level sense with the pin idle low has set the nmi flag; then a filtered rising edge
      `CHK("nmiReq", 1'h1, nmiReq)
      wr(OFF_CTRL, 32'h01090000, 4'hC);
      nmiPin <= 1'h1;
      repeat (30) @(posedge sys_clk);
      chkRd(OFF_CTRL, 32'h01090000);
      wr(OFF_CTRL, 32'h01000000, 4'hC);
      chkRd(OFF_CTRL, 32'h00000000);
      `CHK("nmiReq", 1'h0, nmiReq)
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         d[15:0] = seed;
         seed = lfsr(seed);
         d[31:16] = seed;
         be = beTab[seed[10:8] % 3'h7];
         wr(seed[0] ? OFF_WAKE : OFF_EVOUT, d, be);
         shadow[seed[0]] = merge(shadow[seed[0]], d, be) & 32'h0003FFFF;
         chkRd(seed[0] ? OFF_WAKE : OFF_EVOUT, shadow[seed[0]]);
      end
      `CHK("wakeEn", shadow[1][17:0], cfgOut.wakeEn)
      wr(OFF_CFGA, 32'hFEDCBA98, 4'hF);
      wr(OFF_CFGC, 32'hFFFFF6FF, 4'h2);
      chkRd(OFF_CFGA, 32'h88DCBA98);
      chkRd(OFF_CFGC, 32'h00008000);
      protectOn <= 1'h1;
      wr(OFF_WAKE, 32'h0003FFFF, 4'hF);
      wr(OFF_CTRL, 32'h00000002, 4'h1);
      chkRd(OFF_WAKE, shadow[1]);
      chkRd(OFF_CTRL, 32'h00000000);
      protectOn <= 1'h0;
      // generic clock held still: the handshake cannot finish, so busy must stay up
      genRun <= 1'h0;
      wr(OFF_CTRL, 32'h00000002, 4'h1);
      chkRd(OFF_CTRL, 32'h00008002);
      chkRd(OFF_WAKE, shadow[1]);
      repeat (30) @(posedge sys_clk);
      #1;
      `CHK("sync_in_progress", 1'h1, sync_in_progress)
      genRun <= 1'h1;
      `WAIT(detEnable === 1'h1 && sync_in_progress === 1'h0)
      `CHK("detEnable", 1'h1, detEnable)
      chkRd(OFF_CTRL, 32'h00000002);
      wr(OFF_WAKE, ~shadow[1], 4'hF);
      chkRd(OFF_WAKE, shadow[1]);
      wr(OFF_EVOUT, ~shadow[0], 4'hF);
      chkRd(OFF_EVOUT, shadow[0]);
      // a control write while busy must be parked, never lost
      wr(OFF_CTRL, 32'h00000000, 4'h1);
      wr(OFF_CTRL, 32'h00000002, 4'h1);
      #1;
      `CHK("ctrlStall", 1'h1, ctrlStall)
      `WAIT(ctrlStall === 1'h0 && sync_in_progress === 1'h0 && detEnable === 1'h1)
      `CHK("detEnable", 1'h1, detEnable)
      wr(OFF_IENSET, 32'h00000005, 4'hF);
      partner.pulse(18'h00005);
      chkRd(OFF_IFLAG, 32'h00000005);
      `CHK("irqReq", 1'h1, irqReq)
      wr(OFF_IFLAG, 32'h00000001, 4'hF);
      chkRd(OFF_IFLAG, 32'h00000004);
      wr(OFF_IFLAG, 32'h00000000, 4'hF);
      chkRd(OFF_IFLAG, 32'h00000004);
      `CHK("irqFlags", 18'h00004, irqFlags)
      wr(OFF_IENCLR, 32'h00000004, 4'hF);
      chkRd(OFF_IENSET, 32'h00000001);
      `CHK("irqReq", 1'h0, irqReq)
      // soft reset with the enable bit also set in the same write
      wr(OFF_CTRL, 32'h00000003, 4'h1);
      chkRd(OFF_CTRL, 32'h00008001);
      chkRd(OFF_IFLAG, 32'h00000000);
      chkRd(OFF_WAKE, 32'h00000000);
      `WAIT(sync_in_progress === 1'h0)
      chkRd(OFF_CTRL, 32'h00000000);
      chkRd(OFF_IENSET, 32'h00000000);
      chkRd(OFF_CFGA, 32'h00000000);
      `CHK("detEnable", 1'h0, detEnable)
      finish_test();
   end
endmodule
`default_nettype wire
